/* File: src/peripheral_clock_gate_reg_one.sv */
// first peripheral disable register with apb access and per-unit gates
// assumes apb master on pclk; gate outputs drive clock gates and bus steering
// Overview of operation
// (RQ1) bit 15 set turns timer five off; clear turns it on
// (RQ2) bit 14 set turns timer four off; clear turns it on
// (RQ3) bit 13 set turns timer three off; clear turns it on
// (RQ4) bit 12 set turns timer two off; clear turns it on
// (RQ5) bit 11 set turns timer one off; clear turns it on
// (RQ6) bit 10 set turns encoder one off; clear turns it on
// (RQ7) bit 9 set turns motor pwm one off; clear turns it on
// (RQ8) bit 8 not implemented: reads zero, writes ignored
// (RQ9) bit 7 set turns two-wire unit off; clear turns it on
// (RQ10) bit 6 set turns serial port two off; clear turns it on
// (RQ11) bit 5 set turns serial port one off; clear turns it on
// (RQ12) bit 4 set turns sync serial two off; clear turns it on
// (RQ13) bit 3 gates sync serial one; bit 2 reads zero; reset clears all
// (RQ14) a set bit stops all clocks of that unit
// (RQ15) a disabled unit ignores register writes and reads give invalid data
// (RQ16) any change takes effect one cycle after the write
// (RQ17) bit 1 gates the can unit, bit 0 gates the converter
//
// The address map and the APB register port were decided locally.
module peripheral_clock_gate_reg_one (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] unit_clk_en,
    output logic [15:0] unit_access_en
);
    // ==========================================================
    // register state
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [15:0] gate_clk;
    logic [15:0] gate_acc;
    logic setup;
    logic hit_ctrl;
    logic hit_stat;

    assign setup = psel & ~penable;
    assign hit_ctrl = (paddr == pmd_one_pkg::ctrl_one_addr);
    assign hit_stat = (paddr == pmd_one_pkg::status_addr);

    // ==========================================================
    // apb slave: no wait state, answer in the access cycle
    always_comb begin
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        pready_d = 1'b0;
        if (setup) begin
            pready_d = 1'b1;
            pslverr_d = ~(hit_ctrl | hit_stat);
            prdata_d = '0;
            if (!pwrite && hit_ctrl) begin
                // unimplemented bits masked to zero RQ8
                prdata_d = {16'h0000, ctrl_q & pmd_one_pkg::ctrl_write_mask};
            end else if (!pwrite && hit_stat) begin
                prdata_d = {16'h0000, gate_clk};
            end
        end
        if (psel && penable && pready_q && pwrite && hit_ctrl) begin
            // byte lanes; masked bits never store RQ8 RQ13
            if (pstrb[0]) begin
                ctrl_d[7:0] = pwdata[7:0] & pmd_one_pkg::ctrl_write_mask[7:0];
            end
            if (pstrb[1]) begin
                ctrl_d[15:8] = pwdata[15:8] & pmd_one_pkg::ctrl_write_mask[15:8];
            end
        end
        // pready_d defaults low, so pready stands for one cycle only and drops after each access
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= pmd_one_pkg::ctrl_reset; // RQ13
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ==========================================================
    // per-unit gates; bits 8 and 2 stay clear so their gates stay on
    // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ9 RQ10 RQ11 RQ12 RQ13 RQ17
    genvar g;
    generate
        for (g = 0; g < pmd_one_pkg::reg_width; g++) begin : gen_gate
            unit_gate u_gate (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .off_bit(ctrl_q[g]),
                .clk_en(gate_clk[g]), // RQ14 RQ16
                .access_en(gate_acc[g]) // RQ15
            );
        end
    endgenerate

    assign unit_clk_en = gate_clk;
    assign unit_access_en = gate_acc;

    // ==========================================================
    // checks: clock gates follow the control bits
    chk_timer_five_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        ce |=> (unit_clk_en[pmd_one_pkg::timer_five_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_five_pos])))
        else $error("timer five gate wrong");
    chk_timer_four_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        ce |=> (unit_clk_en[pmd_one_pkg::timer_four_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_four_pos])))
        else $error("timer four gate wrong");
    chk_timer_three_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        ce |=> (unit_clk_en[pmd_one_pkg::timer_three_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_three_pos])))
        else $error("timer three gate wrong");
    chk_timer_two_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        ce |=> (unit_clk_en[pmd_one_pkg::timer_two_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_two_pos])))
        else $error("timer two gate wrong");
    chk_timer_one_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        ce |=> (unit_clk_en[pmd_one_pkg::timer_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_one_pos])))
        else $error("timer one gate wrong");
    chk_encoder_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        ce |=> (unit_clk_en[pmd_one_pkg::encoder_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::encoder_one_pos])))
        else $error("encoder gate wrong");
    chk_pwm_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        ce |=> (unit_clk_en[pmd_one_pkg::motor_pwm_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::motor_pwm_one_pos])))
        else $error("pwm gate wrong");
    chk_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (ctrl_q[8] == 1'b0) && (ctrl_q[2] == 1'b0))
        else $error("unimplemented bit set");
    chk_two_wire_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        ce |=> (unit_clk_en[pmd_one_pkg::two_wire_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::two_wire_one_pos])))
        else $error("two-wire gate wrong");
    chk_serial_two_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        ce |=> (unit_clk_en[pmd_one_pkg::serial_port_two_pos]
                == !$past(ctrl_q[pmd_one_pkg::serial_port_two_pos])))
        else $error("serial two gate wrong");
    chk_serial_one_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        ce |=> (unit_clk_en[pmd_one_pkg::serial_port_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::serial_port_one_pos])))
        else $error("serial one gate wrong");
    chk_sync_two_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        ce |=> (unit_clk_en[pmd_one_pkg::sync_serial_two_pos]
                == !$past(ctrl_q[pmd_one_pkg::sync_serial_two_pos])))
        else $error("sync serial two gate wrong");
    chk_sync_one_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        ce |=> (unit_clk_en[pmd_one_pkg::sync_serial_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::sync_serial_one_pos])))
        else $error("sync serial one gate wrong");
    chk_access_follows: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        unit_access_en == unit_clk_en)
        else $error("access gate differs from clock gate");
    chk_write_delay: assert property (@(posedge pclk) disable iff (!presetn) // RQ14 RQ16
        (ce && psel && penable && pready && pwrite && hit_ctrl && (pstrb == 4'hf)
         && ($past(ce)))
        ##1 ce |=> (unit_clk_en == ~($past(pwdata[15:0], 2)
                                      & pmd_one_pkg::ctrl_write_mask)))
        else $error("gate not applied one cycle after write");
    chk_can_adc_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
        ce |=> ((unit_clk_en[pmd_one_pkg::can_unit_pos]
                 == !$past(ctrl_q[pmd_one_pkg::can_unit_pos]))
                && (unit_clk_en[pmd_one_pkg::converter_one_pos]
                 == !$past(ctrl_q[pmd_one_pkg::converter_one_pos]))))
        else $error("can or converter gate wrong");
    chk_gate_unimpl_on: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        unit_clk_en[8] && unit_clk_en[2])
        else $error("unimplemented gate off");

    // ==========================================================
    // checks: register access gates, one per unit
    chk_timer_five_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ1 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::timer_five_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_five_pos])))
        else $error("timer five access wrong");
    chk_timer_four_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ2 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::timer_four_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_four_pos])))
        else $error("timer four access wrong");
    chk_timer_three_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ3 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::timer_three_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_three_pos])))
        else $error("timer three access wrong");
    chk_timer_two_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ4 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::timer_two_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_two_pos])))
        else $error("timer two access wrong");
    chk_timer_one_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ5 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::timer_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::timer_one_pos])))
        else $error("timer one access wrong");
    chk_encoder_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ6 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::encoder_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::encoder_one_pos])))
        else $error("encoder access wrong");
    chk_pwm_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ7 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::motor_pwm_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::motor_pwm_one_pos])))
        else $error("pwm access wrong");
    chk_two_wire_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ9 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::two_wire_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::two_wire_one_pos])))
        else $error("two-wire access wrong");
    chk_serial_two_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ10 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::serial_port_two_pos]
                == !$past(ctrl_q[pmd_one_pkg::serial_port_two_pos])))
        else $error("serial two access wrong");
    chk_serial_one_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ11 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::serial_port_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::serial_port_one_pos])))
        else $error("serial one access wrong");
    chk_sync_two_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ12 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::sync_serial_two_pos]
                == !$past(ctrl_q[pmd_one_pkg::sync_serial_two_pos])))
        else $error("sync serial two access wrong");
    chk_sync_one_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ13 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::sync_serial_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::sync_serial_one_pos])))
        else $error("sync serial one access wrong");
    chk_can_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ17 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::can_unit_pos]
                == !$past(ctrl_q[pmd_one_pkg::can_unit_pos])))
        else $error("can access wrong");
    chk_converter_access: assert property (@(posedge pclk) disable iff (!presetn) // RQ17 RQ15
        ce |=> (unit_access_en[pmd_one_pkg::converter_one_pos]
                == !$past(ctrl_q[pmd_one_pkg::converter_one_pos])))
        else $error("converter access wrong");

    // ==========================================================
    // checks: bus answer and register contents
    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        (ce && pready) |=> !pready)
        else $error("ready stood longer than one cycle");
    chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        (ce && setup) |=> pready)
        else $error("no answer after setup");
    chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        pslverr |-> pready)
        else $error("error flag without ready");
    chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        (ce && setup && !(hit_ctrl || hit_stat)) |=> pslverr)
        else $error("unmapped access not refused");
    chk_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        pready |-> (prdata[31:16] == 16'h0000))
        else $error("upper read bits not zero");
    chk_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ8 RQ13
        (ce && setup && !pwrite && hit_ctrl)
        |=> ((prdata[15:0] == $past(ctrl_q)) && !prdata[8] && !prdata[2]))
        else $error("control read data wrong");
    chk_status_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
        (ce && setup && !pwrite && hit_stat)
        |=> (prdata[15:0] == $past(unit_clk_en)))
        else $error("status read data wrong");
    chk_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        !(psel && penable && pready && pwrite && hit_ctrl) |=> $stable(ctrl_q))
        else $error("control changed without a write");
    chk_frozen_gates: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        !ce |=> $stable(unit_clk_en))
        else $error("gates moved while frozen");
    chk_frozen_ready: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        !ce |=> ($stable(pready) && $stable(prdata)))
        else $error("bus answer moved while frozen");
endmodule : peripheral_clock_gate_reg_one

/* File: include/pmd_one_pkg.sv */
// constants for the first peripheral disable register block
// assumes an apb slave with 32-bit data and byte addresses
package pmd_one_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] ctrl_one_addr = 12'h000;
    localparam logic [11:0] status_addr = 12'h004;
    localparam int reg_width = 16;
    localparam int unit_count = 14;
    localparam logic [15:0] ctrl_reset = 16'h0000;
    // implemented bits: all but bit 8 and bit 2
    localparam logic [15:0] ctrl_write_mask = 16'hfefb;
    // ==========================================================
    // field positions
    localparam int timer_five_pos = 15;
    localparam int timer_four_pos = 14;
    localparam int timer_three_pos = 13;
    localparam int timer_two_pos = 12;
    localparam int timer_one_pos = 11;
    localparam int encoder_one_pos = 10;
    localparam int motor_pwm_one_pos = 9;
    localparam int two_wire_one_pos = 7;
    localparam int serial_port_two_pos = 6;
    localparam int serial_port_one_pos = 5;
    localparam int sync_serial_two_pos = 4;
    localparam int sync_serial_one_pos = 3;
    localparam int can_unit_pos = 1;
    localparam int converter_one_pos = 0;
    // ==========================================================
    // timing: change applies one instruction cycle after the write
    localparam int apply_delay_cycles = 1;
endpackage : pmd_one_pkg

/* File: src/unit_gate.sv */
// one peripheral gate: clock enable and register-access enable from a disable bit
// assumes pclk domain and a disable bit already held in a register
module unit_gate (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic off_bit,
    output logic clk_en,
    output logic access_en
);
    logic clk_en_q;
    logic clk_en_d;

    always_comb begin
        clk_en_d = ~off_bit;
    end

    // a single registered stage gives the one-cycle delay in both directions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en_q <= 1'b1;
        end else if (ce) begin
            clk_en_q <= clk_en_d;
        end
    end

    assign clk_en = clk_en_q;
    assign access_en = clk_en_q;
endmodule : unit_gate

/* File: tb/tb_top.sv */
// self-checking bench for the first peripheral disable register block
// assumes one apb slave at ctrl_one_addr and status_addr, answering after a bounded wait
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] unit_clk_en;
    logic [15:0] unit_access_en;
    logic [15:0] model_q = 16'h0000;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    // ==========================================================
    // clock, design, watchdog
    always #5 pclk = ~pclk;
    peripheral_clock_gate_reg_one dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .unit_clk_en(unit_clk_en),
        .unit_access_en(unit_access_en));
    // the whole run needs about 630 cycles; a hang ends here
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            summarize();
        end
    end
    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        check("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // model follows byte lanes; unimplemented bits never stick
    task automatic wr_check(input logic [31:0] d, input logic [3:0] s);
        if (s[0]) model_q[7:0] = d[7:0];
        if (s[1]) model_q[15:8] = d[15:8];
        model_q = model_q & pmd_one_pkg::ctrl_write_mask;
        apb(1'b1, pmd_one_pkg::ctrl_one_addr, d, s);
        check("write err", {31'h0, err}, 32'h0);
        @(posedge pclk);
        #1;
        check("clk_en", {16'h0, unit_clk_en}, {16'h0, ~model_q});
        check("access_en", {16'h0, unit_access_en}, {16'h0, ~model_q});
        apb(1'b0, pmd_one_pkg::ctrl_one_addr, 32'h0, 4'h0);
        check("readback", rd, {16'h0, model_q});
        apb(1'b0, pmd_one_pkg::status_addr, 32'h0, 4'h0);
        check("status", rd, {16'h0, ~model_q});
    endtask : wr_check
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hbe17));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check("reset clk_en", {16'h0, unit_clk_en}, 32'h0000ffff);
        apb(1'b0, pmd_one_pkg::ctrl_one_addr, 32'h0, 4'h0);
        check("reset ctrl", rd, 32'h0);
        $display("test reset done");
        // one unit at a time, then every bit at once
        for (int i = 0; i < 16; i++) begin
            wr_check(32'h00000001 << i, 4'h3);
        end
        wr_check(32'hffffffff, 4'hf);
        wr_check(32'h00000000, 4'h3);
        $display("test walking bits done");
        for (int i = 0; i < 40; i++) begin
            wr_check($urandom, 4'($urandom_range(0, 15)));
        end
        $display("test random lanes done");
        // an unmapped place refuses and leaves the control bits alone
        apb(1'b1, 12'h008, 32'hffffffff, 4'hf);
        check("unmapped write err", {31'h0, err}, 32'h1);
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        check("unmapped read err", {31'h0, err}, 32'h1);
        check("unmapped read data", rd, 32'h0);
        wr_check(32'h0000a5a5, 4'h0);
        $display("test unmapped done");
        // reset in mid-run clears a busy register
        wr_check(32'h0000ffff, 4'h3);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        check("rerun clk_en", {16'h0, unit_clk_en}, 32'h0000ffff);
        @(posedge pclk);
        presetn <= 1'b1;
        model_q = 16'h0000;
        wr_check(32'h00000000, 4'h0);
        $display("test second reset done");
        summarize();
    end
endmodule : tb_top
